/* hw/swic_top.sv */
`include "swic_defines.svh"

// Overview of operation
// - GPIO coinciding with timer during sleep dropped
// - Pending registered one cycle before sleep lost
// - Standby/serial sleep refreshes reference every 8 ms
// - Interval select lengthens, disable stops refresh
// - Longer interval may lock; only resets recover
module swic_top #(
    parameter int unsigned REFRESH_CYC = `SWIC_REFRESH_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Interrupt source pins: gpio, general_timer_zero, sleep timer
    input  wire logic [2:0] irq_pin,
    input  wire logic [2:0] irq_enable,
    // Firmware sleep command and configuration
    input  wire logic       sleep_cmd,
    input  wire logic [1:0] sleep_mode,
    input  wire logic [2:0] refresh_interval_select,
    input  wire logic       refresh_disable,
    // Firmware service handshake
    input  wire logic [2:0] irq_ack,
    // Status towards CPU and analog
    output logic      [2:0] irq_pending,
    output logic      [2:0] isr_run,
    output logic            asleep,
    output logic            locked,
    output logic            ref_power_up
);
    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    swic_sync_if #(.W(3)) sif ();
    assign sif.raw = irq_pin;

    swic_sync #(.W(3)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .s     (sif)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        swic_pkg::swic_state_t st;
        logic [2:0]  pend;
        logic [2:0]  run;
        logic [1:0]  age;
        logic [31:0] cnt;
        logic        refresh;
        logic        lock;
        logic        slp;
    } swic_state_bus_t;

    swic_state_bus_t q_reg;
    swic_state_bus_t q_next;

    logic        gpio_ev;
    logic        timer_ev;
    logic        ref_mode;
    logic [31:0] period;
    logic [2:0]  new_ev;

    // ------------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------------
    always_comb begin
        new_ev   = sif.rise & irq_enable;
        gpio_ev  = new_ev[`SWIC_SRC_GPIO];
        timer_ev = new_ev[`SWIC_SRC_GENERAL_TIMER_ZERO] | new_ev[`SWIC_SRC_SLEEP_TMR];
        ref_mode = (sleep_mode == `SWIC_MODE_STANDBY) ||
                   (sleep_mode == `SWIC_MODE_SERIAL);
        period   = 32'(REFRESH_CYC) << refresh_interval_select;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        q_next         = q_reg;
        q_next.refresh = 1'b0;
        if (q_reg.age != 2'h3) begin
            q_next.age = q_reg.age + 2'h1;
        end
        // Service handshake clears the run flag; a new event wins.
        q_next.run = q_reg.run & ~irq_ack;
        case (q_reg.st)
            swic_pkg::SWIC_RUN: begin
                q_next.pend = q_reg.pend | new_ev;
                if (new_ev != 3'h0) begin
                    q_next.age = 2'h0;
                end
                q_next.run = q_next.run | q_reg.pend;
                q_next.pend = q_next.pend & ~q_reg.pend;
                if (sleep_cmd) begin
                    // recent pending lost
                    // Only an event still waiting in pend is lost here;
                    // older ones have already moved to the run flags.
                    if (q_reg.age < 2'(`SWIC_LOSS_WIN_CYC)) begin
                        q_next.pend = 3'h0;
                    end
                    q_next.run = q_reg.run & ~irq_ack;
                    q_next.st  = swic_pkg::SWIC_SLEEP;
                    q_next.cnt = '0;
                end
            end
            swic_pkg::SWIC_SLEEP: begin
                q_next.pend = q_reg.pend | new_ev;
                if (gpio_ev && timer_ev) begin
                    q_next.pend[`SWIC_SRC_GPIO] = q_reg.pend[`SWIC_SRC_GPIO];
                end
                if (ref_mode && !refresh_disable) begin
                    if (q_reg.cnt >= period - 32'h1) begin
                        q_next.cnt     = '0;
                        q_next.refresh = 1'b1;
                    end else begin
                        q_next.cnt = q_reg.cnt + 32'h1;
                    end
                end
                if (q_next.pend != 3'h0) begin
                    if (ref_mode && (refresh_disable ||
                        refresh_interval_select != 3'h0)) begin
                        q_next.st   = swic_pkg::SWIC_LOCK;
                        q_next.lock = 1'b1;
                    end else begin
                        q_next.st = swic_pkg::SWIC_WAKE;
                    end
                end
            end
            swic_pkg::SWIC_WAKE: begin
                q_next.run  = q_next.run | q_reg.pend;
                q_next.pend = 3'h0;
                q_next.age  = 2'h3;
                q_next.st   = swic_pkg::SWIC_RUN;
            end
            swic_pkg::SWIC_LOCK: begin
                q_next.lock = 1'b1;
            end
            default: begin
                q_next.st = swic_pkg::SWIC_RUN;
            end
        endcase
        // Asleep is kept in a flop so that the output needs no decode.
        q_next.slp = (q_next.st != swic_pkg::SWIC_RUN);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg     <= '0;
            q_reg.st  <= swic_pkg::SWIC_RUN;
            q_reg.age <= 2'h3;
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        irq_pending  = q_reg.pend;
        isr_run      = q_reg.run;
        asleep       = q_reg.slp;
        locked       = q_reg.lock;
        ref_power_up = q_reg.refresh;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence sleeping_s;
        q_reg.st == swic_pkg::SWIC_SLEEP;
    endsequence

    gpio_drop_a: assert property (
        sleeping_s and (gpio_ev && timer_ev && !q_reg.pend[0])
        |=> !q_reg.pend[0])
        else $error("gpio event kept beside a timer event");
    late_loss_a: assert property (
        q_reg.st == swic_pkg::SWIC_RUN && sleep_cmd && q_reg.age == 2'h0
        |=> q_reg.pend == 3'h0)
        else $error("late pending survived sleep entry");
    refresh_tick_a: assert property (
        ref_power_up |-> ref_mode || $past(ref_mode))
        else $error("refresh outside a refresh mode");
    refresh_sleep_a: assert property (
        ref_power_up |-> asleep)
        else $error("refresh while awake");
    refresh_off_a: assert property (
        sleeping_s and refresh_disable |=> !ref_power_up)
        else $error("refresh while disabled");
    lock_hold_a: assert property (
        locked |=> locked && asleep)
        else $error("lock left without reset");
    lock_entry_a: assert property (
        sleeping_s and (new_ev != 3'h0) and (ref_mode && refresh_disable)
        |=> locked)
        else $error("no lock with refresh disabled");
    wake_run_a: assert property (
        q_reg.st == swic_pkg::SWIC_WAKE |=> isr_run != 3'h0 && !asleep)
        else $error("no service after wake");
    wake_fast_a: assert property (
        sleeping_s and (new_ev[2:1] != 2'h0) and
        !(ref_mode && (refresh_disable || refresh_interval_select != 3'h0))
        |=> q_reg.st == swic_pkg::SWIC_WAKE)
        else $error("timer event did not wake");
    gpio_wake_a: assert property (
        sleeping_s and (gpio_ev && !timer_ev) and
        !(ref_mode && (refresh_disable || refresh_interval_select != 3'h0))
        |=> q_reg.st == swic_pkg::SWIC_WAKE)
        else $error("gpio event did not wake");
    run_hold_a: assert property (
        isr_run[0] && !irq_ack[0] |=> isr_run[0])
        else $error("gpio service request lost");
    sleep_enter_a: assert property (
        q_reg.st == swic_pkg::SWIC_RUN && sleep_cmd |=> asleep)
        else $error("sleep command ignored");
endmodule

/* hw/swic_defines.svh */
`ifndef SWIC_DEFINES_SVH
`define SWIC_DEFINES_SVH

// Clock rate and refresh timing.
`define SWIC_CLK_HZ          10000000
`define SWIC_REFRESH_MS      8
`define SWIC_REFRESH_CYC     ((`SWIC_CLK_HZ / 1000) * `SWIC_REFRESH_MS)
// Age below which a sleep command clears pend (3 cycles); in RUN, pend is only set at age 0.
`define SWIC_LOSS_WIN_CYC    3
// Interrupt source positions.
`define SWIC_SRC_GPIO        0
`define SWIC_SRC_GENERAL_TIMER_ZERO      1
`define SWIC_SRC_SLEEP_TMR   2
`define SWIC_NSRC            3
// Sleep mode encodings.
`define SWIC_MODE_NORMAL     2'h0
`define SWIC_MODE_STANDBY    2'h1
`define SWIC_MODE_SERIAL     2'h2

`endif

/* hw/swic_pkg.sv */
package swic_pkg;
    typedef enum logic [1:0] {
        SWIC_RUN   = 2'h0,
        SWIC_SLEEP = 2'h1,
        SWIC_WAKE  = 2'h3,
        SWIC_LOCK  = 2'h2
    } swic_state_t;
endpackage

/* hw/swic_sync_if.sv */
interface swic_sync_if #(parameter int W = 3);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] rise;
    modport src (output raw, input level, input rise);
    modport snk (input raw, output level, output rise);
endinterface

/* hw/swic_sync.sv */
// Three-stage synchroniser; a change counts once stages two and three agree.
module swic_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pin side and synchronised side
    swic_sync_if.snk  s
);
    typedef struct packed {
        logic [W-1:0] st1;
        logic [W-1:0] st2;
        logic [W-1:0] st3;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
    } swic_sync_state_t;

    swic_sync_state_t q_reg;
    swic_sync_state_t q_next;

    always_comb begin
        q_next     = q_reg;
        q_next.st1 = s.raw;
        q_next.st2 = q_reg.st1;
        q_next.st3 = q_reg.st2;
        for (int i = 0; i < W; i++) begin
            if (q_reg.st2[i] == q_reg.st3[i]) begin
                q_next.lvl[i] = q_reg.st3[i];
            end
        end
        q_next.rise = q_next.lvl & ~q_reg.lvl;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign s.level = q_reg.lvl;
    assign s.rise  = q_reg.rise;
endmodule

/* verif/swic_fw_model.sv */
// ----------------------------------------
// Firmware and interrupt source stand-in
// ----------------------------------------
module swic_fw_model (
    // Clock
    input  wire logic       clk,
    // Source pins and service handshake
    output logic      [2:0] irq_pin,
    output logic      [2:0] irq_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    int   hold = 0;
    logic gpio_seen;
    initial begin
        irq_pin = 3'h0;
        irq_ack = 3'h0;
    end
    // Pins are held for len cycles; six is enough for the synchroniser.
    always @(posedge clk) begin
        if (hold > 0) begin
            hold <= hold - 1;
            if (hold == 1) irq_pin <= 3'h0;
        end
    end
    task automatic fire(logic [2:0] m, int len);
        irq_pin <= m;
        hold    <= len;
    endtask
    task automatic ack(logic [2:0] m);
        irq_ack <= m;
        if (m[1] || m[2]) gpio_seen = irq_pin[0];
        @(posedge clk);
        irq_ack <= 3'h0;
    endtask
endmodule

/* verif/swic_top_tb.sv */
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
    bad_count++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
// ----------------------------------------
// Testbench
// ----------------------------------------
module swic_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RC = 16;
    logic       clk = 0;
    logic       rst_n, sleep_cmd, refresh_disable;
    logic [2:0] irq_pin, irq_ack, irq_pending, isr_run;
    logic [2:0] irq_enable, refresh_interval_select;
    logic [1:0] sleep_mode;
    logic       asleep, locked, ref_power_up;
    int         bad_count = 0, checks_done = 0, seed = 71, src, n, model_run;
    swic_top #(.REFRESH_CYC(RC)) u_swic_top (.clk(clk), .rst_n(rst_n),
        .irq_pin(irq_pin), .irq_enable(irq_enable), .sleep_cmd(sleep_cmd),
        .sleep_mode(sleep_mode), .refresh_disable(refresh_disable),
        .refresh_interval_select(refresh_interval_select),
        .irq_ack(irq_ack), .irq_pending(irq_pending), .isr_run(isr_run),
        .asleep(asleep), .locked(locked), .ref_power_up(ref_power_up));
    swic_fw_model u_swic_fw_model (.clk(clk), .irq_pin(irq_pin),
        .irq_ack(irq_ack));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic cyc(int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic summarize();
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_run(logic [2:0] m);
        n = 0;
        while ((isr_run & m) !== m && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("isr_run", model_run[2:0], isr_run)
    endtask
    task automatic serve();
        cyc(4);
        u_swic_fw_model.ack(isr_run);
        #1;
        `CHK("isr_clear", 3'h0, isr_run)
        cyc(1);
    endtask
    task automatic go_sleep(logic [1:0] m);
        sleep_mode <= m;
        sleep_cmd  <= 1'b1;
        cyc(1);
        sleep_cmd  <= 1'b0;
        cyc(1);
        #1;
        `CHK("asleep", 1'b1, asleep)
        n = 0;
        repeat (4 * RC) begin
            @(posedge clk);
            #1;
            n += ref_power_up;
        end
        cyc(1);
    endtask
    task automatic reset_dut();
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        #1;
        `CHK("locked", 1'b0, locked)
        cyc(1);
    endtask
    initial begin
        rst_n                   = 1'b0;
        sleep_cmd               = 1'b0;
        refresh_disable         = 1'b0;
        irq_enable              = 3'h7;
        refresh_interval_select = 3'h0;
        sleep_mode              = 2'h1;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        for (int s = 0; s < 3; s++) begin
            u_swic_fw_model.fire(3'h1 << s, 6);
            model_run = 1 << s;
            wait_run(3'h1 << s);
            serve();
        end
        go_sleep(2'h1);
        `CHK("ref_count", 4, n)
        u_swic_fw_model.fire(3'h2, 6);
        model_run = 2;
        wait_run(3'h2);
        `CHK("awake", 1'b0, asleep)
        serve();
        go_sleep(2'h1);
        u_swic_fw_model.fire(3'h3, 20);
        model_run = 2;
        wait_run(3'h2);
        cyc(3);
        #1;
        `CHK("gpio_drop", 3'h2, isr_run)
        serve();
        `CHK("gpio_seen", 1'b1, u_swic_fw_model.gpio_seen)
        cyc(10);
        u_swic_fw_model.fire(3'h1, 6);
        model_run = 1;
        wait_run(3'h1);
        serve();
        irq_enable <= 3'h1;
        go_sleep(2'h1);
        u_swic_fw_model.fire(3'h7, 6);
        model_run = 1;
        wait_run(3'h1);
        serve();
        irq_enable <= 3'h7;
        src = {$random(seed)} % 3;
        u_swic_fw_model.fire(3'h1 << src, 6);
        cyc(5);
        sleep_cmd <= 1'b1;
        cyc(1);
        sleep_cmd <= 1'b0;
        cyc(8);
        #1;
        `CHK("lost_run", 3'h0, isr_run)
        `CHK("lost_sleep", 1'b1, asleep)
        u_swic_fw_model.fire(3'h4, 6);
        model_run = 4;
        wait_run(3'h4);
        cyc(2);
        #1;
        `CHK("late_loss", 3'h4, isr_run)
        serve();
        refresh_interval_select <= 3'h1;
        go_sleep(2'h1);
        `CHK("ref_slow", 2, n)
        u_swic_fw_model.fire(3'h4, 6);
        cyc(10);
        #1;
        `CHK("lock", 2'h3, {locked, asleep})
        `CHK("lock_pend", 3'h4, irq_pending)
        cyc(1);
        reset_dut();
        refresh_interval_select <= 3'h0;
        refresh_disable <= 1'b1;
        go_sleep(2'h2);
        `CHK("ref_off", 0, n)
        u_swic_fw_model.fire(3'h1, 6);
        cyc(10);
        #1;
        `CHK("lock_off", 1'b1, locked)
        cyc(1);
        reset_dut();
        go_sleep(2'h0);
        u_swic_fw_model.fire(3'h1, 6);
        model_run = 1;
        wait_run(3'h1);
        summarize();
    end
    initial begin
        cyc(3000);
        bad_count++;
        summarize();
    end
endmodule
